// *** ldo_cfg_pkg.sv ***
// shared constants and types for the regulator channel configuration bank
package ldo_cfg_pkg;
  // offsets are not all multiples of four: kept as indices, byte address is index times four
  localparam logic [7:0] voltage_index = 8'h38;
  localparam logic [7:0] control_index = 8'h39;
  localparam logic [11:0] voltage_addr = {2'h0, voltage_index, 2'h0};
  localparam logic [11:0] control_addr = {2'h0, control_index, 2'h0};
  // field positions
  localparam int offset_bit_pos = 7;
  localparam int mode_bit_pos = 4;
  localparam int discharge_bit_pos = 3;
  // voltage map in millivolts
  localparam int base_mv = 500;
  localparam int step_mv = 25;
  localparam int offset_mv = 1325;
  // reset values of reserved and offset bits
  localparam logic offset_reset = 1'h0;
  localparam logic [2:0] reserved_reset = 3'h0;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum {slot_assigned, forced_off, forced_on} enable_kind_type;

  // decoded state of the channel, handed to the analog side
  typedef struct packed {
    logic [6:0] target_code;
    logic offset_on;
    logic [12:0] target_mv;
    logic load_switch_mode;
    logic discharge_enable;
    logic [2:0] output_enable_select;
  } channel_cfg_type;
endpackage : ldo_cfg_pkg

// *** ldo_enable_decode.sv ***
// decodes the enable field into slot, forced on and forced off
`timescale 1ns/10ps
module ldo_enable_decode
  import ldo_cfg_pkg::*;
(
  input wire logic [2:0] output_enable_select,
  input wire logic [3:0] slot_active,
  output logic channel_on,
  output logic [1:0] power_sequencer_slot,
  output logic under_sequencer
);
  // top bit picks forced mode, bit 1 picks on versus off
  always_comb begin
    power_sequencer_slot = output_enable_select[1:0];
    under_sequencer = !output_enable_select[2];
    if (!output_enable_select[2]) begin
      channel_on = slot_active[output_enable_select[1:0]];
    end else begin
      channel_on = output_enable_select[1];
    end
  end
endmodule : ldo_enable_decode

// *** ldo_config_registers.sv ***
// axi4-lite register pair configuring the linear regulator channel
// How it works
// - top voltage bit adds 1.325V offset
// - code maps 0.5V plus 25mV steps
// - offset shifts range to 1.825V..5V
// - mode bit 4 selects load switch
// - discharge resistor on when disabled, enabled
// - enable field: slots, forced off, forced on
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module ldo_config_registers
  import ldo_cfg_pkg::*;
#(
  parameter logic [6:0] factory_target_code = 7'h00,
  parameter logic factory_mode = 1'h0,
  parameter logic factory_discharge = 1'h0,
  parameter logic [2:0] factory_enable = 3'h0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] slot_active,
  output channel_cfg_type channel_cfg,
  output logic linear_regulator_channel_on,
  output logic discharge_resistor,
  output logic [1:0] power_sequencer_slot,
  output logic under_sequencer
);
  logic [7:0] voltage_reg;
  logic [7:0] control_reg;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic next_on;
  logic [1:0] next_slot;
  logic next_seq;

  // millivolt target for a code and offset bit
  function automatic logic [12:0] code_to_mv(input logic [6:0] code, input logic off);
    int mv;
    mv = base_mv + step_mv * int'(code) + (off ? offset_mv : 0);
    return mv[12:0];
  endfunction : code_to_mv

  // address channel: accept once, hold until response goes out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'h0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'h1;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'h0;
    end
  end

  // data channel: either order versus the address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'h0;
      w_byte <= 8'h00;
      w_lane <= 1'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'h1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held <= 1'h0;
    end
  end

  // ready only while nothing of that kind is held, so one write at a time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // response after both halves arrive; register update in the same edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= resp_okay;
    end else if (aw_held && w_held && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= (aw_addr == voltage_addr || aw_addr == control_addr) ?
        resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // register storage; reserved bits stored as written, only low byte lane counts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      voltage_reg <= {offset_reset, factory_target_code};
      control_reg <= {reserved_reset, factory_mode, factory_discharge, factory_enable};
    end else if (aw_held && w_held && !s_axi_bvalid && w_lane) begin
      if (aw_addr == voltage_addr) begin
        voltage_reg <= w_byte;
      end
      if (aw_addr == control_addr) begin
        control_reg <= w_byte; // reserved bits stored as written; software writes zero
      end
    end
  end

  // read channel: one-cycle answer, held until rready
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'h0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      if (s_axi_araddr == voltage_addr) begin
        s_axi_rdata <= {24'h000000, voltage_reg};
        s_axi_rresp <= resp_okay;
      end else if (s_axi_araddr == control_addr) begin
        s_axi_rdata <= {24'h000000, control_reg};
        s_axi_rresp <= resp_okay;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= resp_slverr;
      end
    end else begin
      s_axi_arready <= 1'h1;
    end
  end

  ldo_enable_decode u_enable (
    .output_enable_select(control_reg[2:0]),
    .slot_active(slot_active),
    .channel_on(next_on),
    .power_sequencer_slot(next_slot),
    .under_sequencer(next_seq)
  );

  // decoded outputs registered so each leaves from a flip-flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channel_cfg <= '0;
      linear_regulator_channel_on <= 1'h0;
      discharge_resistor <= 1'h0;
      power_sequencer_slot <= 2'h0;
      under_sequencer <= 1'h0;
    end else begin
      channel_cfg.target_code <= voltage_reg[6:0];
      channel_cfg.offset_on <= voltage_reg[offset_bit_pos];
      channel_cfg.target_mv <= code_to_mv(voltage_reg[6:0], voltage_reg[offset_bit_pos]);
      channel_cfg.load_switch_mode <= control_reg[mode_bit_pos];
      channel_cfg.discharge_enable <= control_reg[discharge_bit_pos];
      channel_cfg.output_enable_select <= control_reg[2:0];
      linear_regulator_channel_on <= next_on;
      discharge_resistor <= control_reg[discharge_bit_pos] && !next_on;
      power_sequencer_slot <= next_slot;
      under_sequencer <= next_seq;
    end
  end

  // checks; a sampled !rst keeps the release edge out, its outputs still hold reset values
  a_offset_volts: assert property (@(posedge core_clk) disable iff (rst)
    !rst && voltage_reg[7] |=>
    channel_cfg.target_mv == 13'd1825 + 13'd25 * $past(voltage_reg[6:0]))
    else $error("offset voltage wrong");
  a_base_volts: assert property (@(posedge core_clk) disable iff (rst)
    !rst && !voltage_reg[7] |=>
    channel_cfg.target_mv == 13'd500 + 13'd25 * $past(voltage_reg[6:0]))
    else $error("base voltage wrong");
  a_range_top: assert property (@(posedge core_clk) disable iff (rst)
    !rst && voltage_reg == 8'hff |=> channel_cfg.target_mv == 13'd5000)
    else $error("offset range top not 5V");
  a_mode_select: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> channel_cfg.load_switch_mode == $past(control_reg[4]))
    else $error("mode select wrong");
  a_discharge_on: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> discharge_resistor == ($past(control_reg[3]) && !linear_regulator_channel_on))
    else $error("discharge resistor state wrong");
  a_forced_on: assert property (@(posedge core_clk) disable iff (rst)
    !rst && control_reg[2:1] == 2'h3 |=> linear_regulator_channel_on)
    else $error("forced on not on");
  a_forced_off: assert property (@(posedge core_clk) disable iff (rst)
    !rst && control_reg[2:1] == 2'h2 |=> !linear_regulator_channel_on)
    else $error("forced off not off");
  a_offset_reset: assert property (@(posedge core_clk)
    $fell(rst) |-> voltage_reg[7] == 1'h0 && control_reg[7:5] == 3'h0)
    else $error("reset values wrong");
  a_write_resp: assert property (@(posedge core_clk) disable iff (rst)
    aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response late");
  c_write_done: cover property (@(posedge core_clk) s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (@(posedge core_clk) s_axi_rvalid && s_axi_rready);
  c_discharge: cover property (@(posedge core_clk) discharge_resistor);
  c_offset_used: cover property (@(posedge core_clk) channel_cfg.offset_on);
endmodule : ldo_config_registers

// *** ldo_config_registers_tb_top.sv ***
// self-checking bench for the regulator channel configuration bank
`timescale 1ns/10ps
module ldo_config_registers_tb_top;
  import ldo_cfg_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, slot_active = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_sequencer_slot, rsp;
  logic linear_regulator_channel_on, discharge_resistor, under_sequencer;
  logic [7:0] rd;
  channel_cfg_type channel_cfg;
  int err_count = 0;
  int total_checks = 0;
  // factory values differ from zero so the reset load is visible
  ldo_config_registers #(.factory_target_code(7'h2a), .factory_mode(1'h1),
    .factory_discharge(1'h1), .factory_enable(3'h5)) dut (.core_clk, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .slot_active, .channel_cfg,
    .linear_regulator_channel_on, .discharge_resistor, .power_sequencer_slot,
    .under_sequencer);
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // address and data offered together, each released once taken
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    int n;
    aw_done = 1'h0;
    w_done = 1'h0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done) && n < 100) begin
      @(posedge core_clk);
      n++;
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    // bready stays high until the response is sampled
    while (s_axi_bvalid !== 1'h1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("bvalid_seen", 32'h1, {31'h0, s_axi_bvalid});
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge core_clk);
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_arready !== 1'h1 && n < 100);
    chk("arready_seen", 32'h1, {31'h0, s_axi_arready});
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("rvalid_seen", 32'h1, {31'h0, s_axi_rvalid});
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    chk("rdata_upper", 32'h0, {8'h0, s_axi_rdata[31:8]});
    s_axi_rready <= 1'h0;
    @(posedge core_clk);
  endtask : axi_read
  task automatic test_reset_values();
    axi_read(voltage_addr);
    chk("voltage_reset", 32'h2a, {24'h0, rd});
    chk("rd_okay", {30'h0, resp_okay}, {30'h0, rsp});
    axi_read(control_addr);
    chk("control_reset", 32'h1d, {24'h0, rd});
  endtask : test_reset_values
  // code ends and offset both ways, checked on the decoded millivolts
  task automatic test_voltage_map();
    logic [7:0] v[4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    foreach (v[i]) begin
      axi_write(voltage_addr, v[i]);
      chk("wr_okay", {30'h0, resp_okay}, {30'h0, rsp});
      repeat (2) @(posedge core_clk);
      chk("target_code", {25'h0, v[i][6:0]}, {25'h0, channel_cfg.target_code});
      chk("target_mv", 500 + 25 * v[i][6:0] + (v[i][7] ? 1325 : 0),
        {19'h0, channel_cfg.target_mv});
      chk("offset_on", {31'h0, v[i][7]}, {31'h0, channel_cfg.offset_on});
      axi_read(voltage_addr);
      chk("voltage_rb", {24'h0, v[i]}, {24'h0, rd});
    end
  endtask : test_voltage_map
  task automatic test_mode_select();
    axi_write(control_addr, 8'h16);
    repeat (2) @(posedge core_clk);
    chk("switch_mode", 32'h1, {31'h0, channel_cfg.load_switch_mode});
    axi_write(control_addr, 8'h06);
    repeat (2) @(posedge core_clk);
    chk("linear_mode", 32'h0, {31'h0, channel_cfg.load_switch_mode});
  endtask : test_mode_select
  // every enable code, discharge set; then forced off with discharge clear
  task automatic test_enable_decode();
    logic on;
    slot_active <= 4'h5;
    for (int c = 0; c < 8; c++) begin
      axi_write(control_addr, {5'h01, c[2:0]});
      repeat (3) @(posedge core_clk);
      on = c[2] ? c[1] : slot_active[c[1:0]];
      chk("channel_on", {31'h0, on}, {31'h0, linear_regulator_channel_on});
      chk("discharge", {31'h0, !on}, {31'h0, discharge_resistor});
      chk("slot", c[1:0], {30'h0, power_sequencer_slot});
      chk("under_seq", {31'h0, !c[2]}, {31'h0, under_sequencer});
      chk("enable_field", {29'h0, c[2:0]}, {29'h0, channel_cfg.output_enable_select});
      chk("discharge_en", 32'h1, {31'h0, channel_cfg.discharge_enable});
    end
    axi_write(control_addr, 8'h04);
    repeat (3) @(posedge core_clk);
    chk("no_discharge", 32'h0, {31'h0, discharge_resistor});
  endtask : test_enable_decode
  task automatic test_unmapped();
    axi_write(12'h000, 8'h55);
    chk("wr_slverr", {30'h0, resp_slverr}, {30'h0, rsp});
    axi_read(12'h000);
    chk("rd_slverr", {30'h0, resp_slverr}, {30'h0, rsp});
    chk("rd_zero", 32'h0, {24'h0, rd});
    // byte lane 0 masked: answered okay, register left alone
    s_axi_wstrb <= 4'he;
    axi_write(control_addr, 8'h1b);
    s_axi_wstrb <= 4'hf;
    chk("masked_okay", {30'h0, resp_okay}, {30'h0, rsp});
    axi_read(control_addr);
    chk("control_kept", 32'h04, {24'h0, rd});
  endtask : test_unmapped
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    test_reset_values();
    test_voltage_map();
    test_mode_select();
    test_enable_decode();
    test_unmapped();
    summarize();
  end
  // watchdog, far above the less than a thousand cycles the tests take
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule : ldo_config_registers_tb_top
